// ==== csp_fifo.sv ====
`timescale 1ns/1ps
module csp_fifo
   import csp_pkg::*;
#(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 32
)(
   // clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              resetn_i,
   input  wire logic              ce_i,
   // fill side
   input  wire logic              in_valid_i,
   output logic                   in_ready_o,
   input  wire logic [WIDTH-1:0]  in_data_i,
   // drain side
   output logic                   out_valid_o,
   input  wire logic              out_ready_i,
   output logic      [WIDTH-1:0]  out_data_o
);

   localparam int unsigned AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      cnt_q;
   wire              push_w = in_valid_i & in_ready_o;
   wire              pop_w  = out_valid_o & out_ready_i;

   assign in_ready_o  = (cnt_q != FULL_CNT);
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o  = mem_q[rd_ptr_q];

   always_ff @(posedge clk_sys_i) begin
      if (ce_i && push_w) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   // pointers wrap naturally: depth is a power of two
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q    <= '0;
      end else if (ce_i) begin
         if (push_w) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop_w) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         if (push_w && !pop_w) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop_w && !push_w) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

endmodule

// ==== csp_host_model.sv ====
`timescale 1ns/1ps
module csp_host_model
   import csp_pkg::*;
(
   // mode and requests from the bench
   input  wire logic         master_i,
   input  wire logic         go_i,
   input  wire logic [15:0]  word_i,
   // device pins seen by the host
   input  wire logic         dev_sclk_i,
   input  wire logic         dev_fs_n_i,
   input  wire logic         dout_i,
   input  wire logic         dout_oe_i,
   // host-driven pins
   output logic              sclk_o,
   output logic              fs_n_o,
   output logic              din_o,
   // words taken from the device
   output logic [15:0]       rx_word_o,
   output int                rx_count_o
);
   wire logic   lk_sclk;
   wire logic   lk_fs_n;
   int          idx;
   logic [15:0] shreg;

   assign lk_sclk = master_i ? dev_sclk_i : sclk_o;
   assign lk_fs_n = master_i ? dev_fs_n_i : fs_n_o;

   ////////////////////////////////////////////////////////////////////////////
   // slave timing: clock runs only within a frame, phase unrelated to clk_sys
   initial begin
      sclk_o = 1'b0;
      fs_n_o = 1'b1;
      forever begin
         @(posedge go_i);
         #13;
         for (int i = 0; i < FRAME_SCLKS; i++) begin
            sclk_o = 1'b1;
            fs_n_o = (i == 0) ? 1'b0 : 1'b1;
            #(SCLK_PERIOD_NS / 2);
            sclk_o = 1'b0;
            #(SCLK_PERIOD_NS / 2);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // data: launch on rise, keep stable across the fall; toggle once released
   initial begin
      din_o      = 1'b0;
      idx        = 100;
      shreg      = 16'h0;
      rx_word_o  = 16'h0;
      rx_count_o = 0;
   end

   always @(posedge lk_sclk) begin
      #5;
      if (lk_fs_n === 1'b0) begin
         idx = 0;
      end else begin
         idx++;
      end
      din_o = (idx < WORD_BITS) ? word_i[WORD_BITS-1-idx] : ~din_o;
   end

   // sampled late in the bit so a synchronised slave output has settled
   always @(negedge lk_sclk) begin
      #150;
      if (idx < WORD_BITS) begin
         shreg = {shreg[14:0], dout_oe_i ? dout_i : ~dout_i};
         if (idx == WORD_BITS - 1) begin
            rx_word_o = shreg;
            rx_count_o++;
         end
      end
   end
endmodule

// ==== csp_pkg.sv ====
package csp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // system clock and generated shift clock timing
   localparam int unsigned CLK_SYS_MHZ     = 20;
   localparam int unsigned SCLK_PERIOD_NS  = 400;
   localparam int unsigned SCLK_HALF_CYC   = (SCLK_PERIOD_NS * CLK_SYS_MHZ) / 2000;
   // half-period counter is 3 bits wide, enough for SCLK_HALF_CYC up to 8
   localparam logic [2:0]  HALF_LAST       = 3'(SCLK_HALF_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////
   // frame layout
   localparam int unsigned FRAME_SCLKS     = 32;
   localparam logic [4:0]  FRAME_LAST      = 5'(FRAME_SCLKS - 1);
   localparam int unsigned WORD_BITS       = 16;
   localparam logic [3:0]  WORD_LAST       = 4'(WORD_BITS - 1);
   localparam int unsigned RX_BITS         = 14;
   localparam logic [4:0]  RX_TAKE         = 5'(RX_BITS);
   localparam logic [4:0]  RX_END          = 5'(WORD_BITS);

   ////////////////////////////////////////////////////////////////////////////
   // gain field and buffering
   localparam logic [1:0]  GAIN_SQUELCH    = 2'h0;
   localparam int unsigned FIFO_DEPTH      = 32;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic        FS_IDLE_N       = 1'b1;
   localparam logic [2:0]  SYNC_RST        = 3'h2;

   typedef enum logic [1:0] {
      CSP_IDLE  = 2'b01,
      CSP_SHIFT = 2'b10
   } csp_state_e;

endpackage

// ==== csp_port.sv ====
// Overview of operation
// - a conversion period runs between successive frame sync falls, one word each
// - each serial output bit is launched on a shift clock rising edge
// - each serial input bit is captured on a shift clock falling edge
// - delayed frame sync falls the programmed number of shift clocks after frame sync
// - one delay word programs master and slaves alike, the master's delay half a cycle shorter
// - gain code 00 squelches the result, other codes select gain ranges
// - in master mode delayed frame sync falls half a cycle before its programmed point, leading frame sync at delay 0
// - each frame takes input bits 15 to 2 and sends all sixteen bits
`timescale 1ns/1ps
module csp_port
   import csp_pkg::*;
(
   // clock, reset and enable
   input  wire logic         clk_sys_i,
   input  wire logic         resetn_i,
   input  wire logic         ce_i,
   // mode and programming
   input  wire logic         master_mode_i,
   input  wire logic [4:0]   fsd_delay_i,
   input  wire logic         gain_select_msb_i,
   input  wire logic         gain_select_lsb_i,
   // shift clock pin
   input  wire logic         sclk_i,
   output logic              sclk_o,
   output logic              sclk_oe_o,
   // frame sync pins
   input  wire logic         frame_sync_n_i,
   output logic              frame_sync_n_o,
   output logic              frame_sync_n_oe_o,
   output logic              delayed_frame_sync_n_o,
   // serial data pins
   input  wire logic         serial_in_i,
   output logic              serial_out_o,
   output logic              serial_out_oe_o,
   // converted samples to send
   input  wire logic         adc_valid_i,
   output logic              adc_ready_o,
   input  wire logic [15:0]  adc_data_i,
   // received words and status
   output logic              dac_valid_o,
   output logic [13:0]       dac_data_o,
   output logic [1:0]        gain_range_o,
   output logic              tx_underrun_o
);

   localparam int HALF_A = SCLK_HALF_CYC;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [2:0] pins_s;
   wire        sclk_s = pins_s[2];
   wire        fs_s   = pins_s[1];
   wire        din_s  = pins_s[0];

   csp_sync #(
      .WIDTH   (3),
      .RST_VAL (SYNC_RST)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .ce_i      (ce_i),
      .async_i   ({sclk_i, frame_sync_n_i, serial_in_i}),
      .sync_o    (pins_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // shift clock generation and edge detection
   logic [2:0] half_cnt_q;
   logic       sclk_gen_q;
   logic       sclk_prev_q;
   logic       fs_prev_q;
   logic [4:0] bit_cnt_q;
   logic       fs_gen_n_q;

   wire tick_w      = (half_cnt_q == HALF_LAST);
   wire gen_rise_w  = master_mode_i & tick_w & ~sclk_gen_q;
   wire gen_fall_w  = master_mode_i & tick_w & sclk_gen_q;
   wire ext_rise_w  = ~master_mode_i & sclk_s & ~sclk_prev_q;
   wire ext_fall_w  = ~master_mode_i & ~sclk_s & sclk_prev_q;
   wire rise_w      = gen_rise_w | ext_rise_w;
   wire fall_w      = gen_fall_w | ext_fall_w;
   wire gen_start_w = gen_rise_w & (bit_cnt_q == FRAME_LAST);
   wire ext_start_w = ~master_mode_i & fs_prev_q & ~fs_s;
   wire frame_start_w = gen_start_w | ext_start_w;

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         half_cnt_q <= '0;
         sclk_gen_q <= 1'b0;
      end else if (ce_i) begin
         if (!master_mode_i) begin
            half_cnt_q <= '0;
            sclk_gen_q <= 1'b0;
         end else if (tick_w) begin
            half_cnt_q <= '0;
            sclk_gen_q <= ~sclk_gen_q;
         end else begin
            half_cnt_q <= half_cnt_q + 1'b1;
         end
      end
   end

   // frame sync is low for one shift clock from the rising edge that opens a frame
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bit_cnt_q   <= FRAME_LAST;
         fs_gen_n_q  <= FS_IDLE_N;
         sclk_prev_q <= 1'b0;
         fs_prev_q   <= FS_IDLE_N;
      end else if (ce_i) begin
         sclk_prev_q <= sclk_s;
         fs_prev_q   <= fs_s;
         if (gen_rise_w) begin
            bit_cnt_q  <= bit_cnt_q + 1'b1;
            fs_gen_n_q <= ~(bit_cnt_q == FRAME_LAST);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // delayed frame sync
   logic [4:0] fsd_delay_q;
   logic [4:0] fsd_cnt_q;
   logic       fsd_run_q;
   logic       fsd_n_q;

   // master fires on the fall just before rise number m, half a cycle early
   wire [4:0] bit_next_w = bit_cnt_q + 5'h1;
   wire       gen_fire_w = gen_fall_w & (bit_next_w == fsd_delay_q);
   wire       ext_fire_w = (ext_start_w & (fsd_delay_i == 5'h0))
                         | (ext_rise_w & fsd_run_q & (fsd_cnt_q == 5'h1));
   wire       fsd_fire_w = gen_fire_w | ext_fire_w;
   wire       fsd_rel_w  = master_mode_i ? gen_fall_w : ext_rise_w;

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fsd_delay_q <= '0;
         fsd_cnt_q   <= '0;
         fsd_run_q   <= 1'b0;
         fsd_n_q     <= FS_IDLE_N;
      end else if (ce_i) begin
         if (frame_start_w) begin
            fsd_delay_q <= fsd_delay_i;
         end
         if (ext_start_w) begin
            fsd_cnt_q <= fsd_delay_i;
            fsd_run_q <= (fsd_delay_i != 5'h0);
         end else if (ext_rise_w && fsd_run_q) begin
            fsd_cnt_q <= fsd_cnt_q - 1'b1;
            fsd_run_q <= (fsd_cnt_q != 5'h1);
         end
         if (fsd_fire_w) begin
            fsd_n_q <= 1'b0;
         end else if (fsd_rel_w) begin
            fsd_n_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sample buffer, drained one word per frame
   logic        fifo_valid_w;
   logic [15:0] fifo_data_w;

   csp_fifo #(
      .WIDTH (WORD_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .resetn_i    (resetn_i),
      .ce_i        (ce_i),
      .in_valid_i  (adc_valid_i),
      .in_ready_o  (adc_ready_o),
      .in_data_i   (adc_data_i),
      .out_valid_o (fifo_valid_w),
      .out_ready_i (frame_start_w),
      .out_data_o  (fifo_data_w)
   );

   wire [1:0]  gain_w    = {gain_select_msb_i, gain_select_lsb_i};
   wire        squelch_w = (gain_w == GAIN_SQUELCH);
   // a squelched word still consumes its sample so the stream stays aligned
   wire [15:0] tx_word_w = (fifo_valid_w && !squelch_w) ? fifo_data_w : 16'h0;

   ////////////////////////////////////////////////////////////////////////////
   // word shifter
   csp_state_e  state_q;
   logic [15:0] tx_shift_q;
   logic [3:0]  tx_cnt_q;
   logic [13:0] rx_shift_q;
   logic [4:0]  rx_cnt_q;
   logic        dout_oe_q;
   logic [13:0] dac_data_q;
   logic        dac_valid_q;
   logic [1:0]  gain_q;
   logic        underrun_q;

   wire shifting_w = (state_q == CSP_SHIFT);
   wire tx_last_w  = (tx_cnt_q == WORD_LAST);
   wire rx_open_w  = shifting_w & (rx_cnt_q != RX_END);
   wire rx_done_w  = fall_w & rx_open_w & (rx_cnt_q == 5'(WORD_LAST));

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q    <= CSP_IDLE;
         tx_shift_q <= '0;
         tx_cnt_q   <= '0;
         dout_oe_q  <= 1'b0;
      end else if (ce_i) begin
         case (state_q)
            CSP_IDLE: begin
               if (frame_start_w) begin
                  tx_shift_q <= tx_word_w;
                  tx_cnt_q   <= '0;
                  dout_oe_q  <= 1'b1;
                  state_q    <= CSP_SHIFT;
               end
            end
            CSP_SHIFT: begin
               if (frame_start_w) begin
                  tx_shift_q <= tx_word_w;
                  tx_cnt_q   <= '0;
               end else if (rise_w && tx_last_w) begin
                  dout_oe_q <= 1'b0;
                  state_q   <= CSP_IDLE;
               end else if (rise_w) begin
                  tx_shift_q <= {tx_shift_q[14:0], 1'b0};
                  tx_cnt_q   <= tx_cnt_q + 1'b1;
               end
            end
            default: begin
               state_q   <= CSP_IDLE;
               dout_oe_q <= 1'b0;
            end
         endcase
      end
   end

   // only the first fourteen bits are kept; the last two are control bits
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_shift_q  <= '0;
         rx_cnt_q    <= '0;
         dac_data_q  <= '0;
         dac_valid_q <= 1'b0;
      end else if (ce_i) begin
         dac_valid_q <= rx_done_w;
         if (frame_start_w) begin
            rx_cnt_q <= '0;
         end else if (fall_w && rx_open_w) begin
            rx_cnt_q <= rx_cnt_q + 1'b1;
            if (rx_cnt_q < RX_TAKE) begin
               rx_shift_q <= {rx_shift_q[12:0], din_s};
            end
         end
         if (rx_done_w) begin
            dac_data_q <= rx_shift_q;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gain_q     <= GAIN_SQUELCH;
         underrun_q <= 1'b0;
      end else if (ce_i) begin
         underrun_q <= frame_start_w & ~fifo_valid_w;
         if (frame_start_w) begin
            gain_q <= gain_w;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs; in slave mode the clock and frame sync pins are released, delayed frame sync stays driven
   assign sclk_o                 = sclk_gen_q;
   assign sclk_oe_o              = master_mode_i;
   assign frame_sync_n_o         = fs_gen_n_q;
   assign frame_sync_n_oe_o      = master_mode_i;
   assign delayed_frame_sync_n_o = fsd_n_q;
   assign serial_out_o           = tx_shift_q[15];
   assign serial_out_oe_o        = dout_oe_q;
   assign dac_valid_o            = dac_valid_q;
   assign dac_data_o             = dac_data_q;
   assign gain_range_o           = gain_q;
   assign tx_underrun_o          = underrun_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i || !ce_i);

   sequence s_gen_fall_m0;
      master_mode_i && gen_fall_w && (fsd_delay_q == 5'h0) && (bit_cnt_q == FRAME_LAST);
   endsequence

   sequence s_frame_opens;
      ##[1:HALF_A] gen_start_w;
   endsequence

   frame_load_a: assert property (frame_start_w |=> shifting_w && dout_oe_q && (tx_cnt_q == 4'h0))
      else $error("frame start did not load the shifter");
   bit_launch_a: assert property (shifting_w && $changed(tx_cnt_q) && (tx_cnt_q != 4'h0)
                                  |-> $past(rise_w))
      else $error("output bit advanced off a rising edge");
   bit_capture_a: assert property ($changed(rx_cnt_q) && (rx_cnt_q != 5'h0) |-> $past(fall_w))
      else $error("input bit captured off a falling edge");
   fsd_zero_a: assert property (ext_start_w && (fsd_delay_i == 5'h0) |=> !fsd_n_q)
      else $error("zero delay did not follow frame sync");
   fsd_lead_a: assert property (s_gen_fall_m0 |=> !fsd_n_q ##0 s_frame_opens)
      else $error("delayed sync does not lead frame sync by half a cycle");
   squelch_out_a: assert property (frame_start_w && squelch_w |=> (tx_shift_q == 16'h0))
      else $error("squelch code sent a nonzero word");
   slave_release_a: assert property (!master_mode_i |-> !sclk_oe_o && !frame_sync_n_oe_o)
      else $error("slave drives clock or sync pins");
   sclk_half_a: assert property (master_mode_i && $rose(sclk_gen_q) && $past(master_mode_i)
                                 |=> ($stable(sclk_gen_q) && master_mode_i) [*3])
      else $error("generated shift clock half period too short");
   word_done_a: assert property (dac_valid_o |-> $past(fall_w && rx_cnt_q == 5'(WORD_LAST)))
      else $error("received word flagged before sixteenth bit");

endmodule

// ==== csp_sync.sv ====
`timescale 1ns/1ps
module csp_sync
   import csp_pkg::*;
#(
   parameter int unsigned        WIDTH   = 1,
   parameter logic [WIDTH-1:0]   RST_VAL = '0
)(
   // clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              resetn_i,
   input  wire logic              ce_i,
   // asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0]  async_i,
   output logic      [WIDTH-1:0]  sync_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // meta_q is read by sync_q only
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else if (ce_i) begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule

// ==== tb_codec_serial_frame_port.sv ====
`timescale 1ns/1ps
`define CSP_CHECK(got, exp) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) begin \
         err_count++; \
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
      end \
   end
module tb_codec_serial_frame_port
   import csp_pkg::*;
;
   localparam int FRAME_NS = FRAME_SCLKS * SCLK_PERIOD_NS;

   logic        clk_sys_i;
   logic        resetn_i;
   logic        master_mode_i;
   logic [4:0]  fsd_delay_i;
   logic [1:0]  gain;
   logic        adc_valid_i;
   logic [15:0] adc_data_i;
   logic        sclk_o, sclk_oe_o, frame_sync_n_o, frame_sync_n_oe_o;
   logic        delayed_frame_sync_n_o, serial_out_o, serial_out_oe_o;
   logic        adc_ready_o, dac_valid_o, tx_underrun_o;
   logic [13:0] dac_data_o;
   logic [1:0]  gain_range_o;
   logic        host_sclk, host_fs_n, host_din, go;
   logic [15:0] host_word, rx_word, dac_last;
   logic        lk_fs_n;
   int          rx_count, under_cnt, err_count, checks_done;
   time         t_fs, t_fs_prev, t_sc, t_sc_prev, fsd_dt;

   csp_port u_dut (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(1'b1),
      .master_mode_i(master_mode_i), .fsd_delay_i(fsd_delay_i),
      .gain_select_msb_i(gain[1]), .gain_select_lsb_i(gain[0]),
      .sclk_i(host_sclk), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o),
      .frame_sync_n_i(host_fs_n), .frame_sync_n_o(frame_sync_n_o),
      .frame_sync_n_oe_o(frame_sync_n_oe_o), .delayed_frame_sync_n_o(delayed_frame_sync_n_o),
      .serial_in_i(host_din), .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
      .adc_valid_i(adc_valid_i), .adc_ready_o(adc_ready_o), .adc_data_i(adc_data_i),
      .dac_valid_o(dac_valid_o), .dac_data_o(dac_data_o), .gain_range_o(gain_range_o),
      .tx_underrun_o(tx_underrun_o));

   csp_host_model u_host (
      .master_i(master_mode_i), .go_i(go), .word_i(host_word),
      .dev_sclk_i(sclk_o), .dev_fs_n_i(frame_sync_n_o), .dout_i(serial_out_o),
      .dout_oe_i(serial_out_oe_o), .sclk_o(host_sclk), .fs_n_o(host_fs_n),
      .din_o(host_din), .rx_word_o(rx_word), .rx_count_o(rx_count));

   ////////////////////////////////////////////////////////////////////////////
   // clock and link monitors
   always #25 clk_sys_i = ~clk_sys_i;
   assign lk_fs_n = master_mode_i ? frame_sync_n_o : host_fs_n;
   always @(negedge lk_fs_n) begin
      t_fs_prev = t_fs;
      t_fs = $time;
   end
   always @(negedge delayed_frame_sync_n_o) fsd_dt = $time - t_fs;
   always @(posedge sclk_o) begin
      t_sc_prev = t_sc;
      t_sc = $time;
   end
   always @(posedge clk_sys_i) begin
      if (dac_valid_o === 1'b1) dac_last <= {dac_data_o, 2'b00};
      if (tx_underrun_o === 1'b1) under_cnt <= under_cnt + 1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   task automatic tick();
      @(posedge clk_sys_i);
      #2;
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // waits for one word at the host, then lets the receive pulse land
   task automatic wait_rx();
      int c0;
      c0 = rx_count;
      for (int i = 0; i < 1000 && rx_count == c0; i++) begin
         tick();
      end
      if (rx_count == c0) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, rx_count, c0 + 1);
         summarize();
      end
      repeat (8) tick();
   endtask

   task automatic push(input logic [15:0] w);
      adc_data_i  = w;
      adc_valid_i = 1'b1;
      for (int i = 0; i < 100 && adc_ready_o !== 1'b1; i++) begin
         tick();
      end
      if (adc_ready_o !== 1'b1) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, adc_ready_o, 1'b1);
         summarize();
      end
      tick();
      adc_valid_i = 1'b0;
      // one idle edge so a following push never re-raises valid in the same step
      tick();
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic test_master_frame();
      gain = 2'h1;
      host_word = 16'h3c5a;
      wait_rx();
      push(16'ha5c3);
      wait_rx();
      `CSP_CHECK(rx_word, 16'ha5c3);
      `CSP_CHECK(dac_last[15:2], host_word[15:2]);
      `CSP_CHECK(t_fs - t_fs_prev, time'(FRAME_NS));
      `CSP_CHECK(t_sc - t_sc_prev, time'(SCLK_PERIOD_NS));
      `CSP_CHECK(sclk_oe_o & frame_sync_n_oe_o, 1'b1);
      $display("test master_frame done");
   endtask

   task automatic test_gain_underrun();
      logic [15:0] w;
      int          u0;
      for (int g = 0; g < 4; g++) begin
         w = 16'h7e01 + 16'(g);
         gain = 2'(g);
         push(w);
         wait_rx();
         `CSP_CHECK(rx_word, (g == 0) ? 16'h0 : w);
         `CSP_CHECK(gain_range_o, 2'(g));
      end
      u0 = under_cnt;
      wait_rx();
      `CSP_CHECK(rx_word, 16'h0);
      `CSP_CHECK(under_cnt, u0 + 1);
      $display("test gain_underrun done");
   endtask

   task automatic test_fifo_fill();
      int n;
      n = 0;
      adc_valid_i = 1'b1;
      adc_data_i = 16'h1000;
      while (adc_ready_o === 1'b1 && n < 40) begin
         tick();
         n++;
         adc_data_i = 16'h1000 + 16'(n);
      end
      adc_valid_i = 1'b0;
      `CSP_CHECK(n, FIFO_DEPTH);
      if (n >= 40) summarize();
      for (int k = 0; k < FIFO_DEPTH; k++) begin
         wait_rx();
         `CSP_CHECK(rx_word, 16'h1000 + 16'(k));
      end
      `CSP_CHECK(adc_ready_o, 1'b1);
      $display("test fifo_fill done");
   endtask

   // a fall before the frame start shows up as nearly a whole frame late
   task automatic test_fsd_master();
      int ms[4] = '{0, 1, 5, 31};
      for (int i = 0; i < 4; i++) begin
         fsd_delay_i = 5'(ms[i]);
         repeat (3) wait_rx();
         `CSP_CHECK(fsd_dt, time'((ms[i] * SCLK_PERIOD_NS + FRAME_NS - SCLK_PERIOD_NS / 2) % FRAME_NS));
      end
      $display("test fsd_master done");
   endtask

   task automatic test_slave();
      time lo;
      master_mode_i = 1'b0;
      fsd_delay_i = 5'h3;
      resetn_i = 1'b0;
      repeat (2) tick();
      `CSP_CHECK({sclk_o, frame_sync_n_o, delayed_frame_sync_n_o, serial_out_oe_o}, 4'h6);
      `CSP_CHECK({dac_valid_o, tx_underrun_o, adc_ready_o}, 3'h1);
      `CSP_CHECK({sclk_oe_o, frame_sync_n_oe_o}, 2'h0);
      resetn_i = 1'b1;
      tick();
      push(16'hc3a5);
      push(16'h0ff1);
      host_word = 16'h5a3c;
      for (int f = 0; f < 2; f++) begin
         fsd_delay_i = (f == 0) ? 5'h3 : 5'h0;
         go = 1'b1;
         tick();
         go = 1'b0;
         wait_rx();
         `CSP_CHECK(rx_word, (f == 0) ? 16'hc3a5 : 16'h0ff1);
         `CSP_CHECK(dac_last[15:2], host_word[15:2]);
         `CSP_CHECK({sclk_o, frame_sync_n_o}, 2'h1);
         lo = fsd_delay_i * SCLK_PERIOD_NS;
         `CSP_CHECK(fsd_dt >= lo + 50 && fsd_dt <= lo + 300, 1'b1);
         // the host frame runs all its clocks; a go pulse before its end would be missed
         repeat (FRAME_NS / 50) tick();
      end
      $display("test slave done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys_i = 1'b0;
      resetn_i = 1'b0;
      master_mode_i = 1'b1;
      fsd_delay_i = 5'h0;
      gain = 2'h1;
      adc_valid_i = 1'b0;
      adc_data_i = 16'h0;
      host_word = 16'h0;
      go = 1'b0;
      dac_last = 16'h0;
      {under_cnt, err_count, checks_done} = '0;
      {t_fs, t_fs_prev, t_sc, t_sc_prev, fsd_dt} = '0;
      repeat (4) @(posedge clk_sys_i);
      #2;
      resetn_i = 1'b1;
      test_master_frame();
      test_gain_underrun();
      test_fifo_fill();
      test_fsd_master();
      test_slave();
      summarize();
   end
endmodule
